// ==== rtl/dpcs_defs.svh ====
`ifndef DPCS_DEFS_SVH
`define DPCS_DEFS_SVH

// two-wire chip address, upper seven bits of the first byte
`define DPCS_CHIP_ADDR 7'h1A
// two-wire write of this value to this register index switches to push-pull mode
`define DPCS_MODE_REG 8'h3E
`define DPCS_MODE_VAL 16'h007C

// push-pull command codes
`define DPCS_CMD_SRTA 8'hE8
`define DPCS_CMD_RD8 8'h8B
`define DPCS_CMD_RD16 8'h9C
`define DPCS_CMD_RD32 8'hA6
`define DPCS_CMD_WR8 8'h4E
`define DPCS_CMD_WR16 8'h59
`define DPCS_CMD_WR32 8'h63

// bit slots inside one unit
`define DPCS_DATA_BITS 4'h8
`define DPCS_TW_ACK_SLOT 4'h8
`define DPCS_PP_PAR_SLOT 4'h8
`define DPCS_PP_ACK_SLOT 4'h9

// reset values
`define DPCS_RTA_RST 8'h00

`endif

// ==== rtl/dpcs_pkg.sv ====
package dpcs_pkg;

    typedef enum logic [9:0] {
        ST_IDLE    = 10'h001,
        ST_TW_ADDR = 10'h002,
        ST_TW_WR   = 10'h004,
        ST_TW_RD   = 10'h008,
        ST_PP_CMD  = 10'h010,
        ST_PP_RTA  = 10'h020,
        ST_PP_REG  = 10'h040,
        ST_PP_WR   = 10'h080,
        ST_PP_RD   = 10'h100,
        ST_SKIP    = 10'h200
    } dpcs_state_t;

endpackage

// ==== rtl/dpcs_slave.sv ====
`timescale 1ns/1ps
`include "dpcs_defs.svh"
// Summary of operation
// R1: registers are written and read back over either serial protocol, both on the same clock and data pins.
// R2: once push-pull mode is entered it takes priority and two-wire framing is no longer decoded.
// R3: in two-wire mode the block is a slave only, drives data open-drain, and the host clock stays at 400 KHz or less.
// R4: a two-wire transaction begins when the host pulls data low while the clock is high.
// R5: the first two-wire byte is a 7-bit chip address plus direction bit and only 0011010x is answered.
// R6: after the address is acknowledged, bytes move one at a time in the chosen direction until the end.
// R7: a two-wire transaction ends when the host raises data while the clock is high.
// R8: in push-pull mode the block is one slave of several on a push-pull bus clocked at up to 10MHz.
// R9: a push-pull transaction begins when data falls while the clock is high, then the addressed slave transfers.
// R10: each push-pull unit is followed by a parity bit over the bits before it, which the receiver checks.
// R11: a correct unit gets an active-low acknowledge and a parity error withholds it.
// R12: a set-address command assigns the run-time slave address, which may be changed any number of times.
// R13: push-pull reads return byte, half-word or word data only when the run-time address matches.
// R14: push-pull writes accept byte, half-word or word data only when the run-time address matches.
// R15: the host makes the bus clock and every start and command; the block only samples the clock.
module dpcs_slave (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // shared serial pins
    input wire logic ctrl_clk_in,
    input wire logic ctrl_dat_in,
    output logic ctrl_dat_out,
    output logic ctrl_dat_oe,
    // register port towards the codec
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic [1:0] reg_be,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // status
    output logic pp_mode,
    output logic [7:0] run_time_slave_address
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // byte of a register word for the given byte index: push-pull is low byte first
    function automatic logic [7:0] dpcs_sel_byte(input logic [15:0] w, input logic k0, input logic pp);
        dpcs_sel_byte = (k0 ^ pp) ? w[7:0] : w[15:8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge events

    logic ck_s1_q, ck_s2_q, ck_s3_q;
    logic d_s1_q, d_s2_q, d_s3_q;

    // host clock is only sampled, never generated here  // see R15
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ck_s1_q <= 1'b1;
            ck_s2_q <= 1'b1;
            ck_s3_q <= 1'b1;
            d_s1_q <= 1'b1;
            d_s2_q <= 1'b1;
            d_s3_q <= 1'b1;
        end else begin
            ck_s1_q <= ctrl_clk_in;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            d_s1_q <= ctrl_dat_in;
            d_s2_q <= d_s1_q;
            d_s3_q <= d_s2_q;
        end
    end

    logic clk_rise, clk_fall, start_ev, stop_ev;

    // both protocols share the pins and the same start shape  // see R1
    assign clk_rise = ck_s2_q & ~ck_s3_q;
    assign clk_fall = ~ck_s2_q & ck_s3_q;
    assign start_ev = ck_s2_q & ck_s3_q & ~d_s2_q & d_s3_q; // see R4 // see R9
    assign stop_ev = ck_s2_q & ck_s3_q & d_s2_q & ~d_s3_q; // see R7

    ////////////////////////////////////////////////////////////////////////////////
    // protocol engine

    dpcs_pkg::dpcs_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q, tx_q, ptr_q, lo_q, hi_q, rta_q;
    logic [1:0] k_q;
    logic [2:0] n_q;
    logic is_rd_q, is_srta_q, ack_drv_q, ack_val_q, pp_q, cap_q;
    logic [15:0] rdata_q;
    logic [7:0] rx_byte;
    logic [3:0] ack_slot;
    logic unit_done, par_ok, is_tx;

    assign ack_slot = (pp_q && state_q != dpcs_pkg::ST_TW_WR) ? `DPCS_PP_ACK_SLOT : `DPCS_TW_ACK_SLOT; // see R6
    assign is_tx = (state_q == dpcs_pkg::ST_TW_RD) || (state_q == dpcs_pkg::ST_PP_RD);
    // two-wire finishes on the eighth bit, push-pull on its parity bit
    assign rx_byte = pp_q ? rx_q : {rx_q[6:0], d_s2_q};
    assign par_ok = pp_q ? ((^rx_q) == d_s2_q) : 1'b1; // see R10
    assign unit_done = clk_rise && !is_tx && (state_q != dpcs_pkg::ST_IDLE) && (state_q != dpcs_pkg::ST_SKIP)
        && (cnt_q == (pp_q ? `DPCS_PP_PAR_SLOT : 4'h7));

    // read data is taken the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            cap_q <= reg_rd;
            if (cap_q) begin
                rdata_q <= reg_rdata;
            end
        end
    end

    // sequencing of units, addressing and register strobes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= dpcs_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            lo_q <= 8'h00;
            hi_q <= 8'h00;
            rta_q <= `DPCS_RTA_RST;
            k_q <= 2'h0;
            n_q <= 3'h0;
            is_rd_q <= 1'b0;
            is_srta_q <= 1'b0;
            ack_drv_q <= 1'b0;
            ack_val_q <= 1'b0;
            pp_q <= 1'b0;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            reg_addr <= 8'h00;
            reg_wdata <= 16'h0000;
            reg_be <= 2'h0;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            if (start_ev) begin
                // push-pull mode owns the pins once entered  // see R2
                state_q <= pp_q ? dpcs_pkg::ST_PP_CMD : dpcs_pkg::ST_TW_ADDR;
                cnt_q <= 4'h0;
                ack_drv_q <= 1'b0;
                k_q <= 2'h0;
            end else if (stop_ev) begin
                state_q <= dpcs_pkg::ST_IDLE; // see R7
                ack_drv_q <= 1'b0;
            end else if (clk_rise && state_q != dpcs_pkg::ST_IDLE) begin
                if (cnt_q == ack_slot) begin
                    cnt_q <= 4'h0;
                    ack_drv_q <= 1'b0;
                    if (is_tx) begin
                        if (ack_drv_q) begin
                            tx_q <= dpcs_sel_byte(rdata_q, 1'b0, pp_q);
                        end else if (!pp_q && d_s2_q) begin
                            state_q <= dpcs_pkg::ST_SKIP; // host nack ends the read
                        end else if (pp_q && ({1'b0, k_q} + 3'h1) == n_q) begin
                            state_q <= dpcs_pkg::ST_SKIP; // see R13
                        end else begin
                            k_q <= k_q + 2'h1;
                            tx_q <= dpcs_sel_byte(rdata_q, ~k_q[0], pp_q);
                            // prefetch the next register while its first byte is far away
                            if (!k_q[0]) begin
                                ptr_q <= ptr_q + 8'h01;
                                reg_addr <= ptr_q + 8'h01;
                                reg_rd <= 1'b1;
                            end
                        end
                    end
                end else if (state_q != dpcs_pkg::ST_SKIP) begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q < `DPCS_DATA_BITS) begin
                        rx_q <= {rx_q[6:0], d_s2_q};
                    end
                end
            end
            if (unit_done) begin
                case (state_q)
                    dpcs_pkg::ST_TW_ADDR: begin
                        if (rx_byte[7:1] == `DPCS_CHIP_ADDR) begin // see R5
                            ack_drv_q <= 1'b1; // see R3
                            is_rd_q <= rx_byte[0];
                            if (rx_byte[0]) begin
                                state_q <= dpcs_pkg::ST_TW_RD; // see R6
                                reg_addr <= ptr_q;
                                reg_rd <= 1'b1;
                            end else begin
                                state_q <= dpcs_pkg::ST_TW_WR; // see R6
                            end
                        end else begin
                            state_q <= dpcs_pkg::ST_SKIP;
                        end
                    end
                    dpcs_pkg::ST_TW_WR: begin
                        ack_drv_q <= 1'b1;
                        if (k_q == 2'h0) begin
                            ptr_q <= rx_byte;
                            k_q <= 2'h1;
                        end else if (k_q == 2'h1) begin
                            hi_q <= rx_byte;
                            k_q <= 2'h2;
                        end else begin
                            k_q <= 2'h1;
                            if (ptr_q == `DPCS_MODE_REG && {hi_q, rx_byte} == `DPCS_MODE_VAL) begin
                                pp_q <= 1'b1; // see R2
                            end else begin
                                reg_addr <= ptr_q; // see R1
                                reg_wdata <= {hi_q, rx_byte};
                                reg_be <= 2'h3;
                                reg_wr <= 1'b1;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    dpcs_pkg::ST_PP_CMD: begin
                        // no ack yet: this slave does not know whether it is addressed  // see R8
                        is_srta_q <= (rx_byte == `DPCS_CMD_SRTA);
                        is_rd_q <= rx_byte[7];
                        state_q <= dpcs_pkg::ST_PP_RTA;
                        case (rx_byte)
                            `DPCS_CMD_RD8, `DPCS_CMD_WR8: n_q <= 3'h1;
                            `DPCS_CMD_RD16, `DPCS_CMD_WR16: n_q <= 3'h2;
                            `DPCS_CMD_RD32, `DPCS_CMD_WR32: n_q <= 3'h4;
                            `DPCS_CMD_SRTA: n_q <= 3'h0;
                            default: state_q <= dpcs_pkg::ST_SKIP;
                        endcase
                        if (!par_ok) begin
                            state_q <= dpcs_pkg::ST_SKIP; // see R10
                        end
                    end
                    dpcs_pkg::ST_PP_RTA: begin
                        if (is_srta_q) begin
                            ack_drv_q <= 1'b1;
                            ack_val_q <= ~par_ok; // see R11
                            if (par_ok) begin
                                rta_q <= rx_byte; // see R12
                            end
                            state_q <= dpcs_pkg::ST_SKIP;
                        end else if (rx_byte == rta_q && rta_q != `DPCS_RTA_RST) begin
                            ack_drv_q <= 1'b1; // see R13 // see R14
                            ack_val_q <= ~par_ok; // see R11
                            state_q <= par_ok ? dpcs_pkg::ST_PP_REG : dpcs_pkg::ST_SKIP;
                        end else begin
                            state_q <= dpcs_pkg::ST_SKIP; // not ours: stay off the bus
                        end
                    end
                    dpcs_pkg::ST_PP_REG: begin
                        ack_drv_q <= 1'b1;
                        ack_val_q <= ~par_ok; // see R11
                        ptr_q <= rx_byte;
                        if (!par_ok) begin
                            state_q <= dpcs_pkg::ST_SKIP;
                        end else if (is_rd_q) begin
                            state_q <= dpcs_pkg::ST_PP_RD; // see R13
                            reg_addr <= rx_byte;
                            reg_rd <= 1'b1;
                        end else begin
                            state_q <= dpcs_pkg::ST_PP_WR;
                        end
                    end
                    dpcs_pkg::ST_PP_WR: begin
                        ack_drv_q <= 1'b1;
                        ack_val_q <= ~par_ok; // see R11
                        k_q <= k_q + 2'h1;
                        if (!par_ok) begin
                            state_q <= dpcs_pkg::ST_SKIP; // a bad byte aborts the rest of the write
                        end else begin
                            if (n_q == 3'h1) begin
                                reg_addr <= ptr_q; // see R14
                                reg_wdata <= {8'h00, rx_byte};
                                reg_be <= 2'h1;
                                reg_wr <= 1'b1;
                            end else if (!k_q[0]) begin
                                lo_q <= rx_byte;
                            end else begin
                                reg_addr <= ptr_q; // see R14
                                reg_wdata <= {rx_byte, lo_q};
                                reg_be <= 2'h3;
                                reg_wr <= 1'b1;
                                ptr_q <= ptr_q + 8'h01;
                            end
                            if (({1'b0, k_q} + 3'h1) == n_q) begin
                                state_q <= dpcs_pkg::ST_SKIP;
                            end
                        end
                    end
                    default: begin
                        state_q <= dpcs_pkg::ST_SKIP;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data pin driver, changes only while the host clock is low

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_dat_out <= 1'b0;
            ctrl_dat_oe <= 1'b0;
        end else if (start_ev || stop_ev || state_q == dpcs_pkg::ST_IDLE) begin
            ctrl_dat_out <= 1'b0;
            ctrl_dat_oe <= 1'b0;
        end else if (clk_fall) begin
            if (cnt_q == ack_slot && ack_drv_q) begin
                // two-wire pulls low; push-pull drives low for ack, high to withhold it
                ctrl_dat_out <= pp_q ? ack_val_q : 1'b0; // see R11
                ctrl_dat_oe <= 1'b1;
            end else if (is_tx && cnt_q < `DPCS_DATA_BITS) begin
                // two-wire is open-drain: only a zero is driven, a one is left to the pull-up  // see R3
                ctrl_dat_out <= pp_q ? tx_q[3'h7 - cnt_q[2:0]] : 1'b0;
                ctrl_dat_oe <= pp_q ? 1'b1 : ~tx_q[3'h7 - cnt_q[2:0]];
            end else if (is_tx && pp_q && cnt_q == `DPCS_PP_PAR_SLOT) begin
                ctrl_dat_out <= ^tx_q; // see R10
                ctrl_dat_oe <= 1'b1;
            end else begin
                ctrl_dat_out <= 1'b0;
                ctrl_dat_oe <= 1'b0;
            end
        end
    end

    // status outputs
    assign pp_mode = pp_q;
    assign run_time_slave_address = rta_q;

endmodule

// ==== dv/dpcs_slave_assertions.sv ====
`timescale 1ns/1ps
module dpcs_slave_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // serial pins
    input wire logic ctrl_clk_in,
    input wire logic ctrl_dat_in,
    input wire logic ctrl_dat_out,
    input wire logic ctrl_dat_oe,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // status
    input wire logic pp_mode,
    input wire logic [7:0] run_time_slave_address
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    // pin drive, judged against the raw clock pin since the block only samples it
    a_od_two_wire: assert property (!pp_mode && ctrl_dat_oe |-> !ctrl_dat_out)
        else $error("data driven high in two-wire mode");
    a_drive_clk_low: assert property ($rose(ctrl_dat_oe) |-> !ctrl_clk_in && !$past(ctrl_clk_in))
        else $error("drive started while clock high");
    a_drive_hold_high: assert property (ctrl_clk_in && $past(ctrl_clk_in) && $past(ctrl_clk_in, 2)
        |-> $stable(ctrl_dat_oe) && (!ctrl_dat_oe || $stable(ctrl_dat_out)))
        else $error("drive changed while clock high");
    ////////////////////////////////////////
    // register port strobes follow a host clock rise
    a_wr_on_rise: assert property (reg_wr |-> ctrl_clk_in && $past(ctrl_clk_in))
        else $error("write strobe outside clock high");
    a_rd_then_idle: assert property (reg_rd |=> !reg_rd && !reg_wr)
        else $error("read strobe not single");
    a_tw_full_word: assert property (reg_wr && !pp_mode |-> reg_be == 2'h3)
        else $error("two-wire write not full word");
    a_be_low_byte: assert property (reg_wr |-> reg_be[0])
        else $error("write without low byte enable");
    ////////////////////////////////////////
    // mode and address state
    a_mode_sticky: assert property (pp_mode |=> pp_mode)
        else $error("push-pull mode dropped");
    a_rta_pp_only: assert property ($changed(run_time_slave_address) |-> pp_mode)
        else $error("address changed outside push-pull mode");
    c_mode: cover property ($rose(pp_mode));
    c_wr8: cover property (reg_wr && reg_be == 2'h1);
    c_nack: cover property (ctrl_dat_oe && ctrl_dat_out);
    c_rta: cover property ($changed(run_time_slave_address));
endmodule

bind dpcs_slave dpcs_slave_assertions dpcs_slave_assertions_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .ctrl_clk_in(ctrl_clk_in), .ctrl_dat_in(ctrl_dat_in), .ctrl_dat_out(ctrl_dat_out), .ctrl_dat_oe(ctrl_dat_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pp_mode(pp_mode), .run_time_slave_address(run_time_slave_address));

// ==== dv/dpcs_host.sv ====
`timescale 1ns/1ps
module dpcs_host (
    // block side
    input wire logic pp_mode,
    input wire logic dat_oe,
    input wire logic dat_out,
    // pins
    output logic ctrl_clk,
    output wire logic ctrl_dat
);
    logic host_oe = 1'b0;
    logic host_val = 1'b1;
    logic last = 1'b1;
    logic r;
    logic o;
    initial ctrl_clk = 1'b1;
    ////////////////////////////////////////
    // pull-up in two-wire mode; a released push-pull line shows the inverse of its last level
    assign ctrl_dat = dat_oe ? dat_out : host_oe ? host_val : (pp_mode ? ~last : 1'b1);
    always @(ctrl_dat) if (dat_oe || host_oe) last <= ctrl_dat;
    // one bit: data moves 8 ns after the fall so the block never sees it race the clock
    task automatic hbit(input logic drv, input logic b, output logic s, output logic so);
        #8;
        host_oe = drv && (pp_mode || !b);
        host_val = b;
        #24;
        ctrl_clk = 1'b1;
        s = ctrl_dat;
        so = dat_oe;
        #32;
        ctrl_clk = 1'b0;
    endtask
    task automatic start_cond();
        #8;
        host_oe = pp_mode;
        host_val = 1'b1;
        #24;
        ctrl_clk = 1'b1;
        #32;
        host_oe = 1'b1;
        host_val = 1'b0;
        #32;
        ctrl_clk = 1'b0;
    endtask
    // clock stays high afterwards, standing still between frames
    task automatic stop_cond();
        #8;
        host_oe = 1'b1;
        host_val = 1'b0;
        #24;
        ctrl_clk = 1'b1;
        #32;
        host_oe = pp_mode;
        host_val = 1'b1;
        #32;
    endtask
    task automatic tx8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) hbit(1'b1, b[i], r, o);
    endtask
    task automatic rx8(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) hbit(1'b0, 1'b1, d[i], o);
    endtask
    task automatic tw_wr(input logic [7:0] b, output logic ack);
        tx8(b);
        hbit(1'b0, 1'b1, ack, o);
    endtask
    task automatic tw_rd(output logic [7:0] d, input logic nack);
        rx8(d);
        hbit(1'b1, nack, r, o);
    endtask
    // ack reported as {driven, level}; flip breaks parity on purpose
    task automatic pp_tx(input logic [7:0] b, input logic flip, input logic slot, output logic [1:0] ack);
        tx8(b);
        hbit(1'b1, ^b ^ flip, r, o);
        hbit(1'b0, 1'b1, r, o);
        ack = slot ? {o, r & o} : 2'h0;
    endtask
    task automatic pp_rx(output logic [7:0] d, output logic p);
        rx8(d);
        hbit(1'b0, 1'b1, p, o);
        hbit(1'b0, 1'b1, r, o);
    endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "dpcs_defs.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    wire ctrl_clk_in;
    wire ctrl_dat_in;
    logic ctrl_dat_out, ctrl_dat_oe, reg_wr, reg_rd, pp_mode, a;
    logic [7:0] reg_addr, run_time_slave_address, my_rta, b;
    logic [15:0] reg_wdata, d;
    logic [15:0] reg_rdata = 16'h0000;
    logic [1:0] reg_be, ack;
    logic [15:0] mem [256];
    logic [15:0] exp_mem [256];
    logic [7:0] cmds [6] = '{`DPCS_CMD_WR8, `DPCS_CMD_WR16, `DPCS_CMD_WR32,
        `DPCS_CMD_RD8, `DPCS_CMD_RD16, `DPCS_CMD_RD32};
    logic [25:0] wr_q [$];
    logic [31:0] seed = 32'h00005F12;
    int errors = 0;
    int n_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    dpcs_slave dpcs_slave_i (.sys_clk(sys_clk), .reset_n(reset_n), .ctrl_clk_in(ctrl_clk_in),
        .ctrl_dat_in(ctrl_dat_in), .ctrl_dat_out(ctrl_dat_out), .ctrl_dat_oe(ctrl_dat_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pp_mode(pp_mode), .run_time_slave_address(run_time_slave_address));
    dpcs_host dpcs_host_i (.pp_mode(pp_mode), .dat_oe(ctrl_dat_oe), .dat_out(ctrl_dat_out),
        .ctrl_clk(ctrl_clk_in), .ctrl_dat(ctrl_dat_in));
    ////////////////////////////////////////
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_wr(input logic [25:0] got, input logic [25:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: write got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic exp_wr(input logic [7:0] ad, input logic [15:0] dv, input logic [1:0] be);
        wr_q.push_back({ad, dv, be});
        if (be[0]) exp_mem[ad][7:0] = dv[7:0];
        if (be[1]) exp_mem[ad][15:8] = dv[15:8];
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // register file stand-in; an unexpected write strobe meets an all-unknown note and fails
    always @(negedge sys_clk) begin
        if (reg_wr === 1'b1) begin
            chk_wr({reg_addr, reg_wdata, reg_be}, wr_q.size() ? wr_q.pop_front() : 26'hXXXXXXX);
            mem[reg_addr] <= {reg_be[1] ? reg_wdata[15:8] : mem[reg_addr][15:8],
                reg_be[0] ? reg_wdata[7:0] : mem[reg_addr][7:0]};
        end
        if (reg_rd === 1'b1) reg_rdata <= mem[reg_addr];
    end
    // two-wire write frame: index, then n big-endian words with auto-increment
    task automatic tw_frame(input logic [7:0] idx, input int n, input logic [15:0] d0);
        dpcs_host_i.start_cond();
        dpcs_host_i.tw_wr({`DPCS_CHIP_ADDR, 1'b0}, a);
        chk(a, 1'b0, "chip ack");
        dpcs_host_i.tw_wr(idx, a);
        for (int k = 0; k < n; k++) begin
            if (idx != `DPCS_MODE_REG) exp_wr(idx + 8'(k), d0, 2'h3);
            dpcs_host_i.tw_wr(d0[15:8], a);
            dpcs_host_i.tw_wr(d0[7:0], a);
            chk(a, 1'b0, "data ack");
            d0 = xs();
        end
        dpcs_host_i.stop_cond();
    endtask
    task automatic pp_srta(input logic [7:0] ra, input logic flip);
        dpcs_host_i.start_cond();
        dpcs_host_i.pp_tx(`DPCS_CMD_SRTA, 1'b0, 1'b0, ack);
        dpcs_host_i.pp_tx(ra, flip, 1'b1, ack);
        dpcs_host_i.stop_cond();
        chk(ack, flip ? 2'h3 : 2'h2, "srta ack");
        if (!flip) my_rta = ra;
        chk(run_time_slave_address, my_rta, "rta");
    endtask
    // push-pull access; write data unit number fl carries a broken parity bit
    task automatic pp_xfer(input logic [7:0] cmd, input logic [7:0] ra, input logic [7:0] idx, input int nb,
        input int fl);
        logic [31:0] w;
        w = cmd[7] ? {exp_mem[idx + 8'h01], exp_mem[idx]} : {xs(), xs()};
        dpcs_host_i.start_cond();
        dpcs_host_i.pp_tx(cmd, 1'b0, 1'b0, ack);
        dpcs_host_i.pp_tx(ra, 1'b0, 1'b1, ack);
        chk(ack, ra == my_rta ? 2'h2 : 2'h0, "addr ack");
        if (ra == my_rta) begin
            dpcs_host_i.pp_tx(idx, 1'b0, 1'b1, ack);
            if (!cmd[7] && fl >= nb) begin
                exp_wr(idx, nb == 1 ? {8'h00, w[7:0]} : w[15:0], nb == 1 ? 2'h1 : 2'h3);
                if (nb == 4) exp_wr(idx + 8'h01, w[31:16], 2'h3);
            end
            for (int k = 0; k < nb && k <= fl; k++) begin
                if (cmd[7]) begin
                    dpcs_host_i.pp_rx(b, a);
                    chk(b, w[8 * k +: 8], "read byte");
                    chk(a, ^w[8 * k +: 8], "read parity");
                end else begin
                    dpcs_host_i.pp_tx(w[8 * k +: 8], k == fl, 1'b1, ack);
                    chk(ack, k == fl ? 2'h3 : 2'h2, "data ack");
                end
            end
        end
        dpcs_host_i.stop_cond();
    endtask
    ////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) {mem[i], exp_mem[i]} = 32'h0;
        my_rta = 8'h00;
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        tw_frame(8'h05, 1, 16'h1234);
        tw_frame(8'h06, 2, xs());
        dpcs_host_i.start_cond();
        dpcs_host_i.tw_wr(8'h36, a);
        chk(a, 1'b1, "foreign chip");
        dpcs_host_i.stop_cond();
        tw_frame(8'h05, 0, 16'h0000);
        dpcs_host_i.start_cond();
        dpcs_host_i.tw_wr({`DPCS_CHIP_ADDR, 1'b1}, a);
        for (int k = 0; k < 3; k++) begin
            dpcs_host_i.tw_rd(d[15:8], 1'b0);
            dpcs_host_i.tw_rd(d[7:0], k == 2);
            chk(d, exp_mem[8'h05 + 8'(k)], "tw read");
        end
        dpcs_host_i.stop_cond();
        $display("test two_wire done");
        tw_frame(`DPCS_MODE_REG, 1, `DPCS_MODE_VAL);
        chk(pp_mode, 1'b1, "mode");
        pp_srta(8'h2D, 1'b0);
        pp_srta(8'h4B, 1'b1);
        for (int i = 0; i < 6; i++) pp_xfer(cmds[i], 8'h2D, 8'h10 + 8'(4 * (i % 3)), 1 << (i % 3), 9);
        pp_xfer(`DPCS_CMD_WR16, 8'h2D, 8'h20, 2, 1);
        pp_xfer(`DPCS_CMD_WR32, 8'h17, 8'h24, 4, 9);
        pp_srta(8'h5C, 1'b0);
        pp_xfer(`DPCS_CMD_RD16, 8'h2D, 8'h10, 2, 9);
        pp_xfer(`DPCS_CMD_WR16, 8'h5C, 8'h30, 2, 9);
        pp_xfer(`DPCS_CMD_RD32, 8'h5C, 8'h30, 4, 9);
        repeat (20) @(negedge sys_clk);
        chk(wr_q.size(), 0, "writes left");
        $display("test push_pull done");
        end_sim();
    end
    // watchdog: the sequence needs about 56 us
    initial begin
        #400000;
        errors++;
        end_sim();
    end
endmodule
